// file: pic_top.sv
// priority interrupt controller with wishbone register slave and return stack
//
// Decided for this implementation: the Wishbone register port and the address map.
`include "pic_consts.svh"
`default_nettype none
module pic_top
  import pic_pkg::*;
#(
  parameter int STACK_DEPTH = `PIC_STACK_DEPTH,
  parameter int TICK_DIV    = `PIC_TICK_DIV
)
(
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // interrupt sources
  input  wire logic [8:0]  SRC_EVENT_I,
  input  wire logic [3:0]  TRAP_EVENT_I,
  // cpu side
  input  wire logic        CPU_ACK_I,
  input  wire logic        CPU_RETURN_I,
  input  wire logic [23:0] CPU_PC_I,
  input  wire logic [7:0]  CPU_SRL_I,
  output logic             IRQ_REQ_O,
  output logic      [3:0]  NEW_LEVEL_O,
  output logic      [6:0]  VECTOR_O,
  output logic      [3:0]  CPU_LEVEL_O,
  output logic             RESTORE_VALID_O,
  output logic      [23:0] RESTORE_PC_O,
  output logic      [7:0]  RESTORE_SRL_O,
  // event interrupt
  output logic             IRQ_O
);
  localparam int AW  = $clog2(STACK_DEPTH);
  localparam int SPW = AW + 1;
  localparam int TW  = $clog2(TICK_DIV + 1);
  localparam logic [SPW-1:0] SP_FULL  = SPW'(STACK_DEPTH);
  localparam logic [TW-1:0]  TICK_TOP = TW'(TICK_DIV - 1);

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] dat,
                                       input logic [3:0] sel, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (sel[0])
    begin
      v[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      v[15:8] = dat[15:8];
    end
    return v & mask;
  endfunction

  // bus and register state
  logic          ack_q,     ack_d;
  logic [31:0]   dat_q,     dat_d;
  logic [15:0]   ctrl_q,    ctrl_d;
  logic [15:0]   flag_q,    flag_d;
  logic [15:0]   en_q,      en_d;
  logic [15:0]   prio_a_q,  prio_a_d;
  logic [15:0]   prio_b_q,  prio_b_d;
  logic [15:0]   prio_c_q,  prio_c_d;
  logic [15:0]   timed_interrupt_disable_q,    timed_interrupt_disable_d;
  logic [TW-1:0] tick_q,    tick_d;
  logic [15:0]   evt_en_q,  evt_en_d;
  logic          wb_req;
  logic          lvl_wr;
  // arbitration and cpu state
  pic_pend_type  pend_q,    pend_d;
  pic_state_type state_q,   state_d;
  logic [SPW-1:0] sp_q,     sp_d;
  logic [3:0]    level_q,   level_d;
  logic [15:0]   evt_q,     evt_d;
  logic          irq_q,     irq_d;
  logic          rst_v_q,   rst_v_d;
  logic [23:0]   rst_pc_q,  rst_pc_d;
  logic [7:0]    rst_srl_q, rst_srl_d;
  logic [2:0]    prio [`PIC_N_SRC];
  logic [2:0]    evt_set;
  logic          push, pop;
  pic_frame_type frame, popped;

  // field placement; sources 5-8 share prio_c_q, the other sources sit in prio_a_q and prio_b_q
  always_comb
  begin
    prio[0] = prio_a_q[14:12];
    prio[1] = prio_a_q[6:4];
    prio[2] = prio_b_q[10:8];
    prio[3] = prio_b_q[6:4];
    prio[4] = prio_b_q[2:0];
    prio[5] = prio_c_q[14:12];
    prio[6] = prio_c_q[10:8];
    prio[7] = prio_c_q[6:4];
    prio[8] = prio_c_q[2:0];
  end

  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign lvl_wr = wb_req & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == `PIC_ADR_STATUS_LOW);

  always_comb
  begin
    ack_d    = wb_req;
    dat_d    = 32'h0000_0000;
    ctrl_d   = ctrl_q;
    flag_d   = flag_q;
    en_d     = en_q;
    prio_a_d = prio_a_q;
    prio_b_d = prio_b_q;
    prio_c_d = prio_c_q;
    timed_interrupt_disable_d   = timed_interrupt_disable_q;
    evt_en_d = evt_en_q;
    tick_d   = (tick_q == TICK_TOP) ? '0 : tick_q + TW'(1);
    if ((tick_q == TICK_TOP) && (timed_interrupt_disable_q != 16'h0000))
    begin
      timed_interrupt_disable_d = timed_interrupt_disable_q - 16'h0001;
    end
    if (wb_req && WB_WE_I)
    begin
      unique case (WB_ADR_I)
        `PIC_ADR_CTRL_ONE:   ctrl_d   = wr16(ctrl_q, WB_DAT_I, WB_SEL_I, `PIC_CTRL_MASK);
        `PIC_ADR_FLAGS:      flag_d   = wr16(flag_q, WB_DAT_I, WB_SEL_I, `PIC_SRC_MASK);
        `PIC_ADR_ENABLES:    en_d     = wr16(en_q, WB_DAT_I, WB_SEL_I, `PIC_SRC_MASK);
        `PIC_ADR_PRIO_A:     prio_a_d = wr16(prio_a_q, WB_DAT_I, WB_SEL_I, `PIC_PRIO_A_MASK);
        `PIC_ADR_PRIO_B:     prio_b_d = wr16(prio_b_q, WB_DAT_I, WB_SEL_I, `PIC_PRIO_B_MASK);
        `PIC_ADR_PRIO_C:     prio_c_d = wr16(prio_c_q, WB_DAT_I, WB_SEL_I, `PIC_PRIO_C_MASK);
        `PIC_ADR_TIMED_DIS:  timed_interrupt_disable_d   = wr16(timed_interrupt_disable_q, WB_DAT_I, WB_SEL_I, `PIC_TIMED_INTERRUPT_DISABLE_MASK);
        `PIC_ADR_EVT_ENABLE: evt_en_d = wr16(evt_en_q, WB_DAT_I, WB_SEL_I, `PIC_EVT_MASK);
        default:             dat_d    = 32'h0000_0000;
      endcase
    end
    else if (wb_req)
    begin
      unique case (WB_ADR_I)
        `PIC_ADR_CTRL_ONE:   dat_d = {16'h0000, ctrl_q};
        `PIC_ADR_FLAGS:      dat_d = {16'h0000, flag_q};
        `PIC_ADR_ENABLES:    dat_d = {16'h0000, en_q};
        `PIC_ADR_PRIO_A:     dat_d = {16'h0000, prio_a_q};
        `PIC_ADR_PRIO_B:     dat_d = {16'h0000, prio_b_q};
        `PIC_ADR_PRIO_C:     dat_d = {16'h0000, prio_c_q};
        `PIC_ADR_PENDING:    dat_d = {20'h00000, pend_q.level, 1'b0, pend_q.vector};
        `PIC_ADR_STATUS_LOW: dat_d = {24'h000000, 4'h0, level_q[2:0], 1'b0};
        `PIC_ADR_TIMED_DIS:  dat_d = {16'h0000, timed_interrupt_disable_q};
        `PIC_ADR_EVT_STATUS: dat_d = {16'h0000, evt_q};
        `PIC_ADR_EVT_ENABLE: dat_d = {16'h0000, evt_en_q};
        default:             dat_d = 32'h0000_0000;
      endcase
    end
    // a hardware set in the same cycle as a software clear wins
    flag_d[8:0] = flag_d[8:0] | SRC_EVENT_I;
    ctrl_d[3:0] = ctrl_d[3:0] | TRAP_EVENT_I;
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ack_q    <= 1'b0;
      dat_q    <= 32'h0000_0000;
      ctrl_q   <= 16'h0000;
      flag_q   <= 16'h0000;
      en_q     <= 16'h0000;
      prio_a_q <= `PIC_PRIO_A_RST;
      prio_b_q <= `PIC_PRIO_B_RST;
      prio_c_q <= `PIC_PRIO_C_RST;
      timed_interrupt_disable_q   <= 16'h0000;
      tick_q   <= '0;
      evt_en_q <= 16'h0000;
    end
    else
    begin
      ack_q    <= ack_d;
      dat_q    <= dat_d;
      ctrl_q   <= ctrl_d;
      flag_q   <= flag_d;
      en_q     <= en_d;
      prio_a_q <= prio_a_d;
      prio_b_q <= prio_b_d;
      prio_c_q <= prio_c_d;
      timed_interrupt_disable_q   <= timed_interrupt_disable_d;
      tick_q   <= tick_d;
      evt_en_q <= evt_en_d;
    end
  end

  // arbitration: ties between equal user levels go to the lower source index
  always_comb
  begin
    logic [2:0] best;
    logic [3:0] tlvl;
    logic       ufound, tfound;
    logic [6:0] uvec;
    best   = 3'h0;
    tlvl   = 4'h0;
    ufound = 1'b0;
    tfound = 1'b0;
    uvec   = 7'h00;
    for (int i = 0; i < `PIC_N_SRC; i++)
    begin
      if (flag_q[i] && en_q[i] && (prio[i] != 3'h0) && (prio[i] > best) &&
          !((timed_interrupt_disable_q != 16'h0000) && (prio[i] <= `PIC_TIMED_INTERRUPT_DISABLE_TOP_PRIO)))
      begin
        best   = prio[i];
        ufound = 1'b1;
        uvec   = 7'(i) + `PIC_VEC_USER_BASE;
      end
    end
    if (ctrl_q[`PIC_NEST_DIS_BIT] && (sp_q != '0))
    begin
      ufound = 1'b0;
    end
    for (int k = 0; k < `PIC_N_TRAP; k++)
    begin
      if (ctrl_q[k])
      begin
        tlvl   = `PIC_TRAP_LVL_BASE + 4'(k);
        tfound = 1'b1;
      end
    end
    pend_d = '0;
    if (tfound && (tlvl > level_q))
    begin
      pend_d = '{req: 1'b1, level: tlvl, vector: `PIC_TRAP_VECTOR};
    end
    else if (ufound && ({1'b0, best} > level_q))
    begin
      pend_d = '{req: 1'b1, level: {1'b0, best}, vector: uvec};
    end
    // no request while an ack or a return is being handled
    pend_d.req = pend_d.req & ~CPU_ACK_I & ~CPU_RETURN_I & (state_q == PIC_ST_IDLE);
  end

  // cpu side: entry pushes a frame, return pops it and restores the level
  assign frame = '{pc: CPU_PC_I, status_low_byte: CPU_SRL_I, level: level_q};
  assign push  = CPU_ACK_I & pend_q.req & (sp_q != SP_FULL);
  assign pop   = CPU_RETURN_I & ~(CPU_ACK_I & pend_q.req) & (state_q == PIC_ST_IDLE)
                 & (sp_q != '0);

  always_comb
  begin
    state_d   = state_q;
    sp_d      = sp_q;
    level_d   = level_q;
    rst_v_d   = 1'b0;
    rst_pc_d  = rst_pc_q;
    rst_srl_d = rst_srl_q;
    evt_set   = 3'h0;
    unique case (state_q)
      PIC_ST_IDLE:
      begin
        if (CPU_ACK_I && pend_q.req)
        begin
          level_d = pend_q.level;
          evt_set = {~push, pend_q.level[3], ~pend_q.level[3]};
          if (push)
          begin
            sp_d = sp_q + SPW'(1);
          end
        end
        else if (CPU_RETURN_I)
        begin
          evt_set[2] = ~pop;
          if (pop)
          begin
            sp_d    = sp_q - SPW'(1);
            state_d = PIC_ST_POP;
          end
        end
        else if (lvl_wr)
        begin
          level_d = {level_q[3], WB_DAT_I[3:1]};
        end
      end
      PIC_ST_POP:
      begin
        level_d   = popped.level;
        rst_pc_d  = popped.pc;
        rst_srl_d = popped.status_low_byte;
        rst_v_d   = 1'b1;
        state_d   = PIC_ST_IDLE;
      end
      default:
      begin
        state_d = PIC_ST_IDLE;
      end
    endcase
    evt_d = evt_q | {13'h0000, evt_set};
    if (wb_req && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == `PIC_ADR_EVT_CLEAR))
    begin
      evt_d = (evt_q & ~(WB_DAT_I[15:0] & `PIC_EVT_MASK)) | {13'h0000, evt_set};
    end
    irq_d = |(evt_q & evt_en_q);
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      pend_q    <= '0;
      state_q   <= PIC_ST_IDLE;
      sp_q      <= '0;
      level_q   <= 4'h0;
      evt_q     <= 16'h0000;
      irq_q     <= 1'b0;
      rst_v_q   <= 1'b0;
      rst_pc_q  <= 24'h000000;
      rst_srl_q <= 8'h00;
    end
    else
    begin
      pend_q    <= pend_d;
      state_q   <= state_d;
      sp_q      <= sp_d;
      level_q   <= level_d;
      evt_q     <= evt_d;
      irq_q     <= irq_d;
      rst_v_q   <= rst_v_d;
      rst_pc_q  <= rst_pc_d;
      rst_srl_q <= rst_srl_d;
    end
  end

  pic_stack_mem #(.DEPTH(STACK_DEPTH), .AW(AW)) u_stack (
    .clk_i     (SYS_CLK_I),
    .rst_i     (RST_I),
    .wr_en_i   (push),
    .wr_addr_i (sp_q[AW-1:0]),
    .wr_data_i (frame),
    .rd_en_i   (pop),
    .rd_addr_i (sp_d[AW-1:0]),
    .rd_data_o (popped)
  );

  assign WB_ACK_O        = ack_q;
  assign WB_DAT_O        = dat_q;
  assign IRQ_REQ_O       = pend_q.req;
  assign NEW_LEVEL_O     = pend_q.level;
  assign VECTOR_O        = pend_q.vector;
  assign CPU_LEVEL_O     = level_q;
  assign RESTORE_VALID_O = rst_v_q;
  assign RESTORE_PC_O    = rst_pc_q;
  assign RESTORE_SRL_O   = rst_srl_q;
  assign IRQ_O           = irq_q;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  property p_unused_zero;
    ((prio_a_q & ~`PIC_PRIO_A_MASK) == 16'h0000) && ((prio_c_q & ~`PIC_PRIO_C_MASK) == 16'h0000)
    && ((prio_b_q & ~`PIC_PRIO_B_MASK) == 16'h0000);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused priority bit set");
  property p_above;
    IRQ_REQ_O |-> (NEW_LEVEL_O > $past(level_q));
  endproperty
  a_above: assert property (p_above) else $error("request not above cpu level");
  property p_user_enabled;
    IRQ_REQ_O && !NEW_LEVEL_O[3] |-> $past((flag_q[8:0] & en_q[8:0]) != 9'h000);
  endproperty
  a_user_enabled: assert property (p_user_enabled) else $error("request without flag and enable");
  property p_vec_range;
    IRQ_REQ_O && !NEW_LEVEL_O[3] |-> (VECTOR_O >= 7'h01) && (VECTOR_O <= 7'h09);
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("user vector out of range");
  property p_timed_interrupt_disable;
    IRQ_REQ_O && !NEW_LEVEL_O[3] && $past(timed_interrupt_disable_q != 16'h0000) |-> NEW_LEVEL_O == 4'h7;
  endproperty
  a_timed_interrupt_disable: assert property (p_timed_interrupt_disable) else $error("timed disable let a low level through");
  property p_trap;
    (ctrl_q[3:0] != 4'h0) && (level_q < 4'h8) && (state_q == PIC_ST_IDLE) && !CPU_ACK_I
    && !CPU_RETURN_I |=> IRQ_REQ_O && NEW_LEVEL_O[3];
  endproperty
  a_trap: assert property (p_trap) else $error("pending trap not presented");
  property p_nest;
    ctrl_q[`PIC_NEST_DIS_BIT] && (sp_q != '0) |=> !IRQ_REQ_O || NEW_LEVEL_O[3];
  endproperty
  a_nest: assert property (p_nest) else $error("user interrupt nested while disabled");
  property p_return;
    CPU_RETURN_I && !(CPU_ACK_I && IRQ_REQ_O) && (state_q == PIC_ST_IDLE) && (sp_q != '0)
    |=> !RESTORE_VALID_O ##1 RESTORE_VALID_O && (CPU_LEVEL_O == popped.level)
    && (RESTORE_PC_O == popped.pc) && (RESTORE_SRL_O == popped.status_low_byte);
  endproperty
  a_return: assert property (p_return) else $error("return did not restore");
  property p_ack_drop;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("bus ack held two cycles");
endmodule
`default_nettype wire

// file: pic_consts.svh
// register offsets, field layouts, reset values and counts of the priority interrupt controller
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

`define PIC_ADR_CTRL_ONE     8'h00
`define PIC_ADR_FLAGS        8'h04
`define PIC_ADR_ENABLES      8'h08
`define PIC_ADR_PRIO_A       8'h0c
`define PIC_ADR_PRIO_B       8'h10
`define PIC_ADR_PRIO_C       8'h14
`define PIC_ADR_PENDING      8'h18
`define PIC_ADR_STATUS_LOW   8'h1c
`define PIC_ADR_TIMED_DIS    8'h20
`define PIC_ADR_EVT_STATUS   8'h24
`define PIC_ADR_EVT_CLEAR    8'h28
`define PIC_ADR_EVT_ENABLE   8'h2c

`define PIC_PRIO_A_RST       16'h4040
`define PIC_PRIO_A_MASK      16'h7070
`define PIC_PRIO_B_RST       16'h0444
`define PIC_PRIO_B_MASK      16'h0777
`define PIC_PRIO_C_RST       16'h4444
`define PIC_PRIO_C_MASK      16'h7777

`define PIC_CTRL_MASK        16'h800f
`define PIC_NEST_DIS_BIT     15
`define PIC_SRC_MASK         16'h01ff
`define PIC_TIMED_INTERRUPT_DISABLE_MASK        16'h3fff
`define PIC_EVT_MASK         16'h0007

`define PIC_N_SRC            9
`define PIC_N_TRAP           4
`define PIC_TRAP_LVL_BASE    4'h8
`define PIC_TRAP_VECTOR      7'h00
`define PIC_VEC_USER_BASE    7'h01
`define PIC_TIMED_INTERRUPT_DISABLE_TOP_PRIO    3'h6
`define PIC_STACK_DEPTH      16
`define PIC_TICK_DIV         2

`endif

// file: pic_pkg.sv
// types shared by the priority interrupt controller files
`default_nettype none
package pic_pkg;
  typedef struct packed {
    logic [23:0] pc;
    logic [7:0]  status_low_byte;
    logic [3:0]  level;
  } pic_frame_type;

  typedef struct packed {
    logic       req;
    logic [3:0] level;
    logic [6:0] vector;
  } pic_pend_type;

  typedef enum logic [1:0] {
    PIC_ST_IDLE = 2'b01,
    PIC_ST_POP  = 2'b10
  } pic_state_type;
endpackage
`default_nettype wire

// file: pic_stack_mem.sv
// return stack memory with registered read data
`default_nettype none
module pic_stack_mem
  import pic_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4
)
(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // write port
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire pic_frame_type wr_data_i,
  // read port
  input  wire logic          rd_en_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output var  pic_frame_type rd_data_o
);
  pic_frame_type mem [DEPTH];
  pic_frame_type rd_q;

  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_q <= '0;
    end
    else if (rd_en_i)
    begin
      rd_q <= mem[rd_addr_i];
    end
  end

  assign rd_data_o = rd_q;
endmodule
`default_nettype wire

// file: pic_top_fix_note.sv
// no logic lives here; the controller sits in the top and stack files
`default_nettype none
`default_nettype wire

// file: pic_cpu_model.sv
// behavioural cpu core that takes presented requests and issues returns
`default_nettype none
module pic_cpu_model
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control from the bench
  input  wire logic        ack_en_i,
  input  wire logic [3:0]  wait_i,
  input  wire logic        ret_go_i,
  // controller side
  input  wire logic        irq_req_i,
  output logic             ack_o,
  output logic             ret_o,
  output logic      [23:0] pc_o,
  output logic      [23:0] saved_pc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // pc moves every cycle so a wrong capture edge shows up in the restored frame
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_o      <= 1'b0;
      ret_o      <= 1'b0;
      pc_o       <= 24'h000100;
      saved_pc_o <= 24'h000000;
      cnt_q      <= 4'h0;
    end
    else
    begin
      ack_o <= 1'b0;
      ret_o <= ret_go_i;
      pc_o  <= pc_o + 24'h000002;
      if (ack_o)
        saved_pc_o <= pc_o;
      // wait_i cycles of delay model a slow core; never ack twice for one request
      if (ack_en_i && irq_req_i && !ack_o)
      begin
        if (cnt_q == wait_i)
        begin
          ack_o <= 1'b1;
          cnt_q <= 4'h0;
        end
        else
          cnt_q <= cnt_q + 4'h1;
      end
      else
        cnt_q <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: test_pic_top.sv
// self-checking bench for the priority interrupt controller
`include "pic_consts.svh"
`default_nettype none
module test_pic_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [8:0]  src = 9'h000;
  logic [3:0]  trap = 4'h0;
  logic        ack_en = 1'b0;
  logic        ret_go = 1'b0;
  logic [31:0] dat_o;
  logic        ack, cpu_ack, cpu_ret, irq_req, rv, irq;
  logic [23:0] pc, saved_pc, rpc;
  logic [7:0]  rsrl;
  logic [3:0]  new_lvl, cpu_lvl;
  logic [6:0]  vec;
  logic [2:0]  p;
  logic [15:0] exp_q[$];
  int          err_total = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [7:0]  fadr [9] = '{`PIC_ADR_PRIO_A, `PIC_ADR_PRIO_A, `PIC_ADR_PRIO_B, `PIC_ADR_PRIO_B,
    `PIC_ADR_PRIO_B, `PIC_ADR_PRIO_C, `PIC_ADR_PRIO_C, `PIC_ADR_PRIO_C, `PIC_ADR_PRIO_C};
  int          fsh [9] = '{12, 4, 8, 4, 0, 12, 8, 4, 0};

  always #5 clk = ~clk;

  pic_top #(.STACK_DEPTH(4), .TICK_DIV(2)) dut (.SYS_CLK_I(clk), .RST_I(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SRC_EVENT_I(src), .TRAP_EVENT_I(trap),
    .CPU_ACK_I(cpu_ack), .CPU_RETURN_I(cpu_ret), .CPU_PC_I(pc), .CPU_SRL_I(pc[7:0]),
    .IRQ_REQ_O(irq_req), .NEW_LEVEL_O(new_lvl), .VECTOR_O(vec), .CPU_LEVEL_O(cpu_lvl),
    .RESTORE_VALID_O(rv), .RESTORE_PC_O(rpc), .RESTORE_SRL_O(rsrl), .IRQ_O(irq));

  pic_cpu_model cpu (.clk_i(clk), .rst_i(rst), .ack_en_i(ack_en), .wait_i(4'h3),
    .ret_go_i(ret_go), .irq_req_i(irq_req), .ack_o(cpu_ack), .ret_o(cpu_ret), .pc_o(pc),
    .saved_pc_o(saved_pc));

  task automatic summarize();
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held from launch edge until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {16'h0, d};
    sel <= 4'h3;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0);
  endtask

  task automatic pulse(input logic [8:0] s, input logic [3:0] t);
    @(posedge clk);
    src  <= s;
    trap <= t;
    @(posedge clk);
    src  <= 9'h000;
    trap <= 4'h0;
  endtask

  // request outputs answer one cycle after the cause; two edges let it land
  task automatic see(input logic i, input logic r, input logic [3:0] l, input logic [6:0] v);
    repeat (2) @(posedge clk);
    #1;
    chk({irq, irq_req, new_lvl, vec}, {i, r, l, v});
  endtask

  // read data is taken only at the edge where ack is sampled high
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0)
      chk(dat_o, {16'h0, exp_q.pop_front()});
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  initial
  begin
    void'($urandom(32'h93967e1a));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(`PIC_ADR_PRIO_A, `PIC_PRIO_A_RST);
    rd(`PIC_ADR_PRIO_B, `PIC_PRIO_B_RST);
    rd(`PIC_ADR_PRIO_C, `PIC_PRIO_C_RST);
    for (int k = 0; k < 3; k++)
    begin
      wr(fadr[k * 2 + (k > 1)], 16'hffff);
    end
    rd(`PIC_ADR_PRIO_A, 16'h7070);
    rd(`PIC_ADR_PRIO_B, 16'h0777);
    rd(`PIC_ADR_PRIO_C, 16'h7777);
    wr(8'h40, 16'hffff);
    rd(8'h40, 16'h0000);
    wr(`PIC_ADR_PENDING, 16'hffff);
    rd(`PIC_ADR_PENDING, 16'h0000);
    for (int i = 0; i < 9; i++)
    begin
      p = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom_range(7, 1));
      wr(fadr[i], 16'(p) << fsh[i]);
      pulse(9'h001 << i, 4'h0);
      see(0, 0, 4'h0, 7'h00);
      wr(`PIC_ADR_ENABLES, 16'h0001 << i);
      see(0, p != 0, (p != 0) ? {1'b0, p} : 4'h0, (p != 0) ? 7'(i + 1) : 7'h00);
      rd(`PIC_ADR_PENDING, (p != 0) ? {5'h0, p, 1'b0, 7'(i + 1)} : 16'h0);
      wr(`PIC_ADR_FLAGS, 16'h0000);
    end
    wr(`PIC_ADR_PRIO_A, 16'h3050);
    wr(`PIC_ADR_ENABLES, 16'h0003);
    pulse(9'h003, 4'h0);
    see(0, 1, 4'h5, 7'h02);
    wr(`PIC_ADR_STATUS_LOW, 16'h000e);
    see(0, 0, 4'h0, 7'h00);
    pulse(9'h000, 4'h1);
    see(0, 1, 4'h8, 7'h00);
    see(0, 1, 4'h8, 7'h00);
    wr(`PIC_ADR_CTRL_ONE, 16'h0000);
    see(0, 0, 4'h0, 7'h00);
    wr(`PIC_ADR_STATUS_LOW, 16'h0000);
    wr(`PIC_ADR_FLAGS, 16'h0000);
    wr(`PIC_ADR_PRIO_A, 16'h6070);
    wr(`PIC_ADR_TIMED_DIS, 16'h0040);
    pulse(9'h001, 4'h0);
    see(0, 0, 4'h0, 7'h00);
    pulse(9'h002, 4'h0);
    see(0, 1, 4'h7, 7'h02);
    wr(`PIC_ADR_FLAGS, 16'h0001);
    see(0, 0, 4'h0, 7'h00);
    repeat (130) @(posedge clk);
    see(0, 1, 4'h6, 7'h01);
    wr(`PIC_ADR_FLAGS, 16'h0000);
    wr(`PIC_ADR_EVT_ENABLE, 16'h0001);
    wr(`PIC_ADR_PRIO_A, 16'h5000);
    pulse(9'h001, 4'h0);
    ack_en <= 1'b1;
    for (int k = 0; k < 20 && cpu_lvl !== 4'h5; k++)
      @(posedge clk);
    ack_en <= 1'b0;
    see(1, 0, 4'h0, 7'h00);
    chk(cpu_lvl, 4'h5);
    rd(`PIC_ADR_EVT_STATUS, 16'h0001);
    wr(`PIC_ADR_EVT_ENABLE, 16'h0000);
    see(0, 0, 4'h0, 7'h00);
    wr(`PIC_ADR_EVT_CLEAR, 16'h0001);
    wr(`PIC_ADR_EVT_ENABLE, 16'h0001);
    see(0, 0, 4'h0, 7'h00);
    wr(`PIC_ADR_CTRL_ONE, 16'h8000);
    wr(`PIC_ADR_PRIO_A, 16'h5070);
    pulse(9'h002, 4'h0);
    see(0, 0, 4'h0, 7'h00);
    wr(`PIC_ADR_CTRL_ONE, 16'h0000);
    see(0, 1, 4'h7, 7'h02);
    @(posedge clk);
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    for (int k = 0; k < 10 && rv !== 1'b1; k++)
      @(posedge clk);
    chk({rsrl, rpc}, {saved_pc[7:0], saved_pc});
    chk(cpu_lvl, 4'h0);
    see(0, 1, 4'h7, 7'h02);
    // a return with an empty stack must only raise the stack error event
    @(posedge clk);
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    rd(`PIC_ADR_EVT_STATUS, 16'h0004);
    summarize();
  end
endmodule
`default_nettype wire
